// File: src/pfm_pin_mux.v
// pin-function multiplexer: port b line four and port f lines zero-three
// assumes software writes through load strobes, pins sampled every clock
`include "pfm_regs.vh"

module pfm_pin_mux
(
    // clock and reset
    input wire clock,
    input wire resetn,

    // port b direction register write
    input wire pb_dir_load,
    input wire [`PFM_PB_W-1:0] pb_dir_wdata,
    // port b data register write
    input wire pb_data_load,
    input wire [`PFM_PB_W-1:0] pb_data_wdata,
    // port b pullup enable write
    input wire pb_pull_load,
    input wire [`PFM_PB_W-1:0] pb_pull_wdata,
    // port b peripheral enable write
    input wire pb_per_load,
    input wire [`PFM_PB_W-1:0] pb_per_wdata,

    // port f direction register write
    input wire pf_dir_load,
    input wire [`PFM_PF_W-1:0] pf_dir_wdata,
    // port f data register write
    input wire pf_data_load,
    input wire [`PFM_PF_W-1:0] pf_data_wdata,
    // port f pullup enable write
    input wire pf_pull_load,
    input wire [`PFM_PF_W-1:0] pf_pull_wdata,
    // port f peripheral enable write
    input wire pf_per_load,
    input wire [`PFM_PF_W-1:0] pf_per_wdata,

    // clock-out select write
    input wire cko_load,
    input wire cko_wdata,
    // bus control register write, drive select bit
    input wire bus_ctrl_load,
    input wire bus_ctrl_wdata,

    // register readback
    output wire [`PFM_PB_W-1:0] pb_dir_q,
    output wire [`PFM_PB_W-1:0] pb_data_q,
    output wire [`PFM_PB_W-1:0] port_b_pullup_enable,
    output wire [`PFM_PB_W-1:0] port_b_peripheral_enable,
    output wire [`PFM_PF_W-1:0] pf_dir_q,
    output wire [`PFM_PF_W-1:0] pf_data_q,
    output wire [`PFM_PF_W-1:0] port_f_pullup_enable,
    output wire [`PFM_PF_W-1:0] pf_per_q,
    output wire clock_out_select,
    output wire bus_drive_select,

    // external memory interface side
    input wire xbus_active,
    input wire address_line_twenty,
    input wire [`PFM_PF_W-1:0] xbus_data_out,
    input wire xbus_data_oe,
    output reg [`PFM_PF_W-1:0] xbus_data_in_reg,
    output reg xbus_ctrl_oe_reg,

    // clock generator side
    input wire prescaler_clock,

    // port b line four pad
    input wire port_b_line_four_in,
    output reg port_b_line_four_out_reg,
    output reg port_b_line_four_oe_reg,
    output reg port_b_line_four_pull_reg,
    output reg port_b_line_four_state_reg,

    // port f pads, bit 0 is port_f_line_zero
    input wire [`PFM_PF_W-1:0] port_f_in,
    output reg [`PFM_PF_W-1:0] port_f_out_reg,
    output reg [`PFM_PF_W-1:0] port_f_oe_reg,
    output reg [`PFM_PF_W-1:0] port_f_pull_reg,
    output reg [`PFM_PF_W-1:0] port_f_state_reg
);

    // bus pins drive while a cycle runs, or always if selected
    function bus_drives;
        input active;
        input drive_sel;
        begin
            bus_drives = active | (drive_sel == `PFM_BUSDRIVE_ALWAYS);
        end
    endfunction

    // port b pad, next values from the cell
    wire pb_out_next;
    wire pb_oe_next;
    wire pb_pull_next;
    // port b peripheral drive
    reg pb_alt_out;
    reg pb_alt_oe;
    // port f pads, next values from the cells
    wire [`PFM_PF_W-1:0] pf_out_next;
    wire [`PFM_PF_W-1:0] pf_oe_next;
    wire [`PFM_PF_W-1:0] pf_pull_next;
    // bus drive window for address, data and controls
    wire bus_window;

    // port b direction, one bit per line
    pfm_cfg_reg #(.W(`PFM_PB_W), .RST(`PFM_PB_DIR_RST)) u_pb_dir
    (
        .clock(clock),
        .resetn(resetn),
        .load(pb_dir_load),
        .wdata(pb_dir_wdata),
        .q(pb_dir_q)
    );

    // port b output data
    pfm_cfg_reg #(.W(`PFM_PB_W), .RST(`PFM_PB_DATA_RST)) u_pb_data
    (
        .clock(clock),
        .resetn(resetn),
        .load(pb_data_load),
        .wdata(pb_data_wdata),
        .q(pb_data_q)
    );

    // port b pullup enable, line four enabled at reset
    pfm_cfg_reg #(.W(`PFM_PB_W), .RST(`PFM_PB_PULL_RST)) u_pb_pull
    (
        .clock(clock),
        .resetn(resetn),
        .load(pb_pull_load),
        .wdata(pb_pull_wdata),
        .q(port_b_pullup_enable)
    );

    // port b peripheral enable, gpio at reset
    pfm_cfg_reg #(.W(`PFM_PB_W), .RST(`PFM_PB_PER_RST)) u_pb_per
    (
        .clock(clock),
        .resetn(resetn),
        .load(pb_per_load),
        .wdata(pb_per_wdata),
        .q(port_b_peripheral_enable)
    );

    // port f direction
    pfm_cfg_reg #(.W(`PFM_PF_W), .RST(`PFM_PF_DIR_RST)) u_pf_dir
    (
        .clock(clock),
        .resetn(resetn),
        .load(pf_dir_load),
        .wdata(pf_dir_wdata),
        .q(pf_dir_q)
    );

    // port f output data
    pfm_cfg_reg #(.W(`PFM_PF_W), .RST(`PFM_PF_DATA_RST)) u_pf_data
    (
        .clock(clock),
        .resetn(resetn),
        .load(pf_data_load),
        .wdata(pf_data_wdata),
        .q(pf_data_q)
    );

    // port f pullups, all enabled at reset
    pfm_cfg_reg #(.W(`PFM_PF_W), .RST(`PFM_PF_PULL_RST)) u_pf_pull
    (
        .clock(clock),
        .resetn(resetn),
        .load(pf_pull_load),
        .wdata(pf_pull_wdata),
        .q(port_f_pullup_enable)
    );

    // port f owner, data bus at reset
    // the bus function is absent in this package, so software
    // is expected to clear these bits; we do not force it
    pfm_cfg_reg #(.W(`PFM_PF_W), .RST(`PFM_PF_PER_RST)) u_pf_per
    (
        .clock(clock),
        .resetn(resetn),
        .load(pf_per_load),
        .wdata(pf_per_wdata),
        .q(pf_per_q)
    );

    // clock-out select, address at reset
    pfm_cfg_reg #(.W(1), .RST(`PFM_CKO_RST)) u_cko
    (
        .clock(clock),
        .resetn(resetn),
        .load(cko_load),
        .wdata(cko_wdata),
        .q(clock_out_select)
    );

    // bus drive select, idle tri-state at reset
    pfm_cfg_reg #(.W(1), .RST(`PFM_BUSDRIVE_RST)) u_drv
    (
        .clock(clock),
        .resetn(resetn),
        .load(bus_ctrl_load),
        .wdata(bus_ctrl_wdata),
        .q(bus_drive_select)
    );

    // one decode shared by every bus-owned pad
    assign bus_window = bus_drives(xbus_active, bus_drive_select);

    // line four alternate: prescaler monitor or address twenty
    always @*
    begin
        if (clock_out_select == `PFM_CKO_PRESCALER)
        begin
            // clock monitor drives continuously
            pb_alt_out = prescaler_clock;
            pb_alt_oe = 1'b1;
        end
        else
        begin
            // address line idles per drive select
            pb_alt_out = address_line_twenty;
            pb_alt_oe = bus_window;
        end
    end

    // port b line four cell
    pfm_pin_cell u_pb_cell
    (
        .periph_sel(port_b_peripheral_enable[`PFM_PB_LINE]),
        .gpio_dir(pb_dir_q[`PFM_PB_LINE]),
        .gpio_data(pb_data_q[`PFM_PB_LINE]),
        .pull_en(port_b_pullup_enable[`PFM_PB_LINE]),
        .alt_out(pb_alt_out),
        .alt_oe(pb_alt_oe),
        .pad_out(pb_out_next),
        .pad_oe(pb_oe_next),
        .pad_pull(pb_pull_next)
    );

    // port f cells, line n uses bit n of each register
    genvar gi;
    generate
        for (gi = `PFM_PF_LINE0; gi < `PFM_PF_W; gi = gi + 1)
        begin : g_pf
            pfm_pin_cell u_pf_cell
            (
                .periph_sel(pf_per_q[gi]),
                .gpio_dir(pf_dir_q[gi]),
                .gpio_data(pf_data_q[gi]),
                .pull_en(port_f_pullup_enable[gi]),
                .alt_out(xbus_data_out[gi]),
                .alt_oe(xbus_data_oe & bus_window),
                .pad_out(pf_out_next[gi]),
                .pad_oe(pf_oe_next[gi]),
                .pad_pull(pf_pull_next[gi])
            );
        end
    endgenerate

    // port b pad flops; reset leaves an input with pullup enabled
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            port_b_line_four_out_reg <= `PFM_PAD_CLEAR_RST;
            port_b_line_four_oe_reg <= `PFM_PAD_CLEAR_RST;
            port_b_line_four_pull_reg <= `PFM_PAD_PULL_RST;
            port_b_line_four_state_reg <= `PFM_PAD_CLEAR_RST;
        end
        else
        begin
            port_b_line_four_out_reg <= pb_out_next;
            port_b_line_four_oe_reg <= pb_oe_next;
            port_b_line_four_pull_reg <= pb_pull_next;
            // pad level sampled for software readback
            port_b_line_four_state_reg <= port_b_line_four_in;
        end
    end

    // port f pad flops; reset leaves outputs off, pullups enabled
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            port_f_out_reg <= `PFM_PF_DATA_RST;
            port_f_oe_reg <= `PFM_PF_DIR_RST;
            port_f_pull_reg <= `PFM_PF_PULL_RST;
            port_f_state_reg <= `PFM_PF_DATA_RST;
        end
        else
        begin
            port_f_out_reg <= pf_out_next;
            port_f_oe_reg <= pf_oe_next;
            port_f_pull_reg <= pf_pull_next;
            port_f_state_reg <= port_f_in;
        end
    end

    // bus-facing flops: read data and control enable
    // one cycle of latency is traded for clean registered pads
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            xbus_data_in_reg <= `PFM_PF_DATA_RST;
            xbus_ctrl_oe_reg <= `PFM_PAD_CLEAR_RST;
        end
        else
        begin
            // read data only meaningful while lines are bus-owned
            xbus_data_in_reg <= port_f_in & pf_per_q;
            xbus_ctrl_oe_reg <= bus_window;
        end
    end

endmodule // pfm_pin_mux

// File: src/pfm_regs.vh
// constants for the port b / port f pin-function multiplexer
// assumes one 125 MHz clock and an active-low asynchronous reset
// Summary of operation
// - port b line four direction set by software
// - reset: line four input, pullup enabled, gpio
// - clearing port b pullup bit 4 disables pullup
// - bus drive select idles address twenty, controls
// - peripheral enable releases line four from gpio
// - clock-out select picks address or prescaler clock
// - bus drive select idles data lines seven-ten
// - each port f pin direction set independently
// - port f resets data-bus, undriven, pullup enabled
// - clearing port f pullup bit n clears line n pullup
`ifndef PFM_REGS_VH
`define PFM_REGS_VH

// register widths
`define PFM_PB_W 8
`define PFM_PF_W 4

// field positions
`define PFM_PB_LINE 4
`define PFM_PF_LINE0 0

// reset values, port b registers
`define PFM_PB_DIR_RST 8'h00
`define PFM_PB_DATA_RST 8'h00
`define PFM_PB_PULL_RST 8'h10
`define PFM_PB_PER_RST 8'h00

// reset values, port f registers
`define PFM_PF_DIR_RST 4'h0
`define PFM_PF_DATA_RST 4'h0
`define PFM_PF_PULL_RST 4'hF
`define PFM_PF_PER_RST 4'hF

// clock-out select encodings and reset value
`define PFM_CKO_ADDR 1'b0
`define PFM_CKO_PRESCALER 1'b1
`define PFM_CKO_RST 1'b0

// bus drive select: 0 idles the bus, 1 drives always
`define PFM_BUSDRIVE_IDLE_OFF 1'b0
`define PFM_BUSDRIVE_ALWAYS 1'b1
`define PFM_BUSDRIVE_RST 1'b0

// pad flop reset values: not driving, pullup enabled
`define PFM_PAD_CLEAR_RST 1'b0
`define PFM_PAD_PULL_RST 1'b1

`endif

// File: src/pfm_cfg_reg.v
// one software-loaded configuration register
// assumes load strobes are synchronous to clock
module pfm_cfg_reg
#(
    parameter W = 1,
    parameter [W-1:0] RST = {W{1'b0}}
)
(
    // clock and reset
    input wire clock,
    input wire resetn,
    // software write
    input wire load,
    input wire [W-1:0] wdata,
    // stored value
    output reg [W-1:0] q
);

    // constant at reset, new value at load
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            q <= RST;
        end
        else if (load)
        begin
            q <= wdata;
        end
    end

endmodule // pfm_cfg_reg

// File: src/pfm_pin_cell.v
// combinational mux for one multiplexed pin
// assumes the caller registers out, oe and pull
module pfm_pin_cell
(
    // ownership
    input wire periph_sel,
    // gpio settings
    input wire gpio_dir,
    input wire gpio_data,
    input wire pull_en,
    // peripheral drive
    input wire alt_out,
    input wire alt_oe,
    // pad controls
    output reg pad_out,
    output reg pad_oe,
    output reg pad_pull
);

    // choose owner, pullup only while not driving
    always @*
    begin
        if (periph_sel)
        begin
            // peripheral owns the pad
            pad_out = alt_out;
            pad_oe = alt_oe;
        end
        else
        begin
            // bus activity has no say here
            pad_out = gpio_data;
            pad_oe = gpio_dir;
        end
        // a pullup fighting our own driver wastes current
        pad_pull = pull_en & ~pad_oe;
    end

endmodule // pfm_pin_cell

// File: sim/pfm_pin_mux_chk.sv
// assertions over the pin-function multiplexer ports
// assumes a bind onto pfm_pin_mux, one clock, async low reset
module pfm_pin_mux_chk
(
    // clock and reset
    input logic clock,
    input logic resetn,
    // register readback
    input logic [7:0] pb_dir_q,
    input logic [7:0] port_b_pullup_enable,
    input logic [7:0] port_b_peripheral_enable,
    input logic [3:0] pf_dir_q,
    input logic [3:0] pf_per_q,
    input logic [3:0] port_f_pullup_enable,
    input logic clock_out_select,
    input logic bus_drive_select,
    // bus and clock sources
    input logic xbus_active,
    input logic address_line_twenty,
    input logic xbus_data_oe,
    input logic prescaler_clock,
    // pad controls
    input logic port_b_line_four_out_reg,
    input logic port_b_line_four_oe_reg,
    input logic port_b_line_four_pull_reg,
    input logic [3:0] port_f_oe_reg,
    input logic [3:0] port_f_pull_reg,
    input logic xbus_ctrl_oe_reg
);
    logic up_reg; // low until one edge after release
    // $past still holds reset-time config at the first edge
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            up_reg <= 1'b0;
        else
            up_reg <= 1'b1;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn || !up_reg);

    a_pb_gpio_dir: assert property (
        !$past(port_b_peripheral_enable[4]) |->
        port_b_line_four_oe_reg == $past(pb_dir_q[4]))
        else $error("line four enable differs from gpio direction");
    a_pb_pull_off: assert property (
        port_b_line_four_pull_reg ==
        ($past(port_b_pullup_enable[4]) & !port_b_line_four_oe_reg))
        else $error("line four pullup wrong");
    a_pb_addr_out: assert property (
        $past(port_b_peripheral_enable[4] & !clock_out_select) |->
        port_b_line_four_oe_reg == $past(xbus_active | bus_drive_select)
        && port_b_line_four_out_reg == $past(address_line_twenty))
        else $error("line four address drive wrong");
    a_pb_clk_mon: assert property (
        $past(port_b_peripheral_enable[4] & clock_out_select) |->
        port_b_line_four_oe_reg
        && port_b_line_four_out_reg == $past(prescaler_clock))
        else $error("line four clock monitor wrong");
    a_ctrl_idle_off: assert property (
        xbus_ctrl_oe_reg == $past(xbus_active | bus_drive_select))
        else $error("control enable wrong");
    a_pf_drive_sel: assert property (
        port_f_oe_reg == (($past(pf_per_q) & {4{$past(xbus_data_oe
        & (xbus_active | bus_drive_select))}})
        | $past(~pf_per_q & pf_dir_q)))
        else $error("port f enable wrong");
    a_pf_pull_off: assert property (
        port_f_pull_reg == ($past(port_f_pullup_enable) & ~port_f_oe_reg))
        else $error("port f pullup wrong");
    a_reset_cfg: assert property (disable iff (!resetn)
        !up_reg |-> port_f_oe_reg == 4'h0 && port_f_pull_reg == 4'hF
        && pf_per_q == 4'hF && !port_b_line_four_oe_reg
        && port_b_line_four_pull_reg && !port_b_peripheral_enable[4])
        else $error("reset configuration wrong");
endmodule // pfm_pin_mux_chk

bind pfm_pin_mux pfm_pin_mux_chk pfm_pin_mux_chk_inst (.clock, .resetn,
    .pb_dir_q, .port_b_pullup_enable, .port_b_peripheral_enable,
    .pf_dir_q, .pf_per_q, .port_f_pullup_enable, .clock_out_select,
    .bus_drive_select, .xbus_active, .address_line_twenty,
    .xbus_data_oe, .prescaler_clock, .port_b_line_four_out_reg,
    .port_b_line_four_oe_reg, .port_b_line_four_pull_reg,
    .port_f_oe_reg, .port_f_pull_reg, .xbus_ctrl_oe_reg);

// File: sim/pfm_mem_model.sv
// external memory and pad wiring beside the multiplexer
// assumes the bench commands memory read drive
module pfm_mem_model
(
    // clock and reset
    input logic clock,
    input logic resetn,
    // memory read drive
    input logic rd_en,
    input logic [3:0] rd_data,
    // pad controls from the device
    input logic [3:0] pf_out,
    input logic [3:0] pf_oe,
    input logic [3:0] pf_pull,
    input logic pb_out,
    input logic pb_oe,
    input logic pb_pull,
    // resolved pad levels
    output logic [3:0] port_f_in,
    output logic port_b_line_four_in
);
    logic [3:0] churn_reg; // floating pad stand-in, never settles
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            churn_reg <= 4'hA;
        else
            churn_reg <= ~churn_reg;
    // device drive wins; memory only drives an undriven line
    always_comb
        for (int i = 0; i < 4; i++)
            port_f_in[i] = pf_oe[i] ? pf_out[i] : rd_en ? rd_data[i] :
                pf_pull[i] ? 1'b1 : churn_reg[i];
    assign port_b_line_four_in = pb_oe ? pb_out : pb_pull ? 1'b1 :
        churn_reg[0];
endmodule // pfm_mem_model

// File: sim/pfm_pin_mux_tb.sv
// self-checking bench for the pin-function multiplexer
// assumes the memory model resolves every pad level
module pfm_pin_mux_tb;
    timeunit 1ns;
    timeprecision 100ps;
`define PFM_EQ(n, e, s) begin checks++; if ((s) !== (e)) begin \
    mismatches++; $display("unexpected %s exp %h seen %h", n, e, s); end end
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    logic clock, resetn, cko_load, cko_wdata, bus_ctrl_load, bus_ctrl_wdata;
    logic [3:0] ld, fl, fq [4], fw [4], sf [4], xbus_data_out, port_f_in;
    logic [7:0] pw [4], pq [4], sp [4];
    logic xbus_active, address_line_twenty, xbus_data_oe, prescaler_clock;
    logic qcko, qdrv; // select readbacks
    logic [3:0] fo, foe, pfo, pfoe, pfp, pfs, din;
    logic pbo, pboe, pbp, pbs, ctl, port_b_line_four_in, rd_en, scko, sdrv;
    logic [3:0] rd_data;
    logic [3:0] e_pb;
    logic [19:0] e_pf;
    logic e_ctl, po, poe, act;

    pfm_pin_mux pfm_pin_mux_inst (.clock, .resetn,
        .pb_dir_load(ld[0]), .pb_dir_wdata(pw[0]), .pb_data_load(ld[1]),
        .pb_data_wdata(pw[1]), .pb_pull_load(ld[2]), .pb_pull_wdata(pw[2]),
        .pb_per_load(ld[3]), .pb_per_wdata(pw[3]), .pf_dir_load(fl[0]),
        .pf_dir_wdata(fw[0]), .pf_data_load(fl[1]), .pf_data_wdata(fw[1]),
        .pf_pull_load(fl[2]), .pf_pull_wdata(fw[2]), .pf_per_load(fl[3]),
        .pf_per_wdata(fw[3]), .cko_load, .cko_wdata, .bus_ctrl_load,
        .bus_ctrl_wdata,
        .pb_dir_q(pq[0]), .pb_data_q(pq[1]), .port_b_pullup_enable(pq[2]),
        .port_b_peripheral_enable(pq[3]), .pf_dir_q(fq[0]),
        .pf_data_q(fq[1]), .port_f_pullup_enable(fq[2]), .pf_per_q(fq[3]),
        .clock_out_select(qcko), .bus_drive_select(qdrv), .xbus_active,
        .address_line_twenty, .xbus_data_out, .xbus_data_oe,
        .xbus_data_in_reg(din), .xbus_ctrl_oe_reg(ctl), .prescaler_clock,
        .port_b_line_four_in, .port_b_line_four_out_reg(pbo),
        .port_b_line_four_oe_reg(pboe), .port_b_line_four_pull_reg(pbp),
        .port_b_line_four_state_reg(pbs), .port_f_in,
        .port_f_out_reg(pfo), .port_f_oe_reg(pfoe), .port_f_pull_reg(pfp),
        .port_f_state_reg(pfs));
    pfm_mem_model pfm_mem_model_inst (.clock, .resetn, .rd_en, .rd_data,
        .pf_out(pfo), .pf_oe(pfoe), .pf_pull(pfp), .pb_out(pbo),
        .pb_oe(pboe), .pb_pull(pbp), .port_f_in, .port_b_line_four_in);

    // free-running 8 ns clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // hang guard, well above the planned run length
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // expectation for the next edge, from shadow config before its loads
    task automatic predict();
        #1;
        act = xbus_active | sdrv;
        if (!sp[3][4])
            {po, poe} = {sp[1][4], sp[0][4]};
        else if (scko)
            {po, poe} = {prescaler_clock, 1'b1};
        else
            {po, poe} = {address_line_twenty, act};
        fo = (sf[3] & xbus_data_out) | (~sf[3] & sf[1]);
        foe = (sf[3] & {4{xbus_data_oe & act}}) | (~sf[3] & sf[0]);
        e_pb = {po, poe, sp[2][4] & ~poe, port_b_line_four_in};
        e_pf = {fo, foe, sf[2] & ~foe, port_f_in, port_f_in & sf[3]};
        e_ctl = act;
        for (int i = 0; i < 4; i++)
        begin
            if (ld[i])
                sp[i] = pw[i];
            if (fl[i])
                sf[i] = fw[i];
        end
        if (cko_load)
            scko = cko_wdata;
        if (bus_ctrl_load)
            sdrv = bus_ctrl_wdata;
    endtask

    // hold reset 12 cycles, check reset state, release
    task automatic do_reset();
        // drive reset stimulus at the same offset as every step
        @(posedge clock);
        #1;
        {ld, fl, cko_load, bus_ctrl_load, xbus_active, xbus_data_oe} = 0;
        {rd_en, address_line_twenty, prescaler_clock} = 0;
        resetn = 1'b0;
        repeat (12) @(posedge clock);
        #1;
        `PFM_EQ("pb reset", {2'b01, 8'h00, 8'h10}, {pboe, pbp, pq[3], pq[2]})
        `PFM_EQ("pf reset", {4'h0, 4'hF, 4'hF}, {pfoe, pfp, fq[3]})
        `PFM_EQ("sel reset", 2'b00, {qcko, qdrv})
        sp = '{8'h00, 8'h00, 8'h10, 8'h00};
        sf = '{4'h0, 4'h0, 4'hF, 4'hF};
        {scko, sdrv} = 2'b00;
        resetn = 1'b1;
        predict();
    endtask

    // compare the last edge, then drive new random inputs
    task automatic step(input int mode);
        @(posedge clock);
        #1;
        for (int i = 0; i < 4; i++)
        begin
            `PFM_EQ("pb readback", sp[i], pq[i])
            `PFM_EQ("pf readback", sf[i], fq[i])
        end
        `PFM_EQ("pb pad", e_pb, {pbo, pboe, pbp, pbs})
        `PFM_EQ("pf pad", e_pf, {pfo, pfoe, pfp, pfs, din})
        `PFM_EQ("ctl oe", e_ctl, ctl)
        `PFM_EQ("sel readback", {scko, sdrv}, {qcko, qdrv})
        ld = $urandom;
        fl = $urandom;
        for (int i = 0; i < 4; i++)
        begin
            pw[i] = $urandom;
            fw[i] = $urandom;
        end
        if (mode == 1)
            {fl[3], fw[3]} = 5'h10;
        if (mode == 2)
            fl[3] = 1'b0;
        {cko_load, cko_wdata, bus_ctrl_load, bus_ctrl_wdata} = $urandom;
        {xbus_active, address_line_twenty, xbus_data_oe} = $urandom;
        {prescaler_clock, rd_data, xbus_data_out} = $urandom;
        rd_en = (mode == 0) & $urandom;
        predict();
    endtask

    // reset, random port f ownership with memory reads, gpio port f, mid-run reset
    initial
    begin
        resetn = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            pw[i] = 8'h00;
            fw[i] = 4'h0;
        end
        {cko_wdata, bus_ctrl_wdata, xbus_data_out, rd_data} = 0;
        void'($urandom(32'hfc3ba252));
        do_reset();
        $display("test reset done");
        repeat (400) step(0);
        $display("test bus traffic done");
        step(1);
        repeat (400) step(2);
        $display("test gpio port f done");
        do_reset();
        repeat (50) step(0);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // pfm_pin_mux_tb
